//--- lfbe_pkg.sv
package lfbe_pkg;
  // *****************************************
  // Widths and timing
  // *****************************************
  localparam int AW          = 16;
  localparam int CLK_HZ      = 25000000;
  localparam int AN_WAIT_US  = 2000;
  localparam int AN_WAIT_CYC = AN_WAIT_US * (CLK_HZ / 1000000);
  localparam int SLOT_BITS   = 512;
  localparam logic [3:0] MAX_RETRY = 4'hf;
  localparam int AN_EN_BIT   = 9;
  // *****************************************
  // Block layout, word offsets from base
  // *****************************************
  localparam logic [AW-1:0] TX_STAT_OFS = 16'h0000;
  localparam logic [AW-1:0] TX_LEN_OFS  = 16'h0001;
  localparam logic [AW-1:0] TX_DATA_OFS = 16'h0002;
  localparam logic [AW-1:0] RX_EVT_OFS  = 16'h0000;
  localparam logic [AW-1:0] RX_STAT_OFS = 16'h0001;
  localparam logic [AW-1:0] RX_CNT_OFS  = 16'h0002;
  localparam logic [AW-1:0] RX_NXT_OFS  = 16'h0003;
  localparam logic [AW-1:0] RX_HDR_LEN  = 16'h0004;
  localparam logic [15:0]   RX_EVT_DONE = 16'h0008;
  // *****************************************
  // Carried groups
  // *****************************************
  typedef struct packed {
    logic deferred_flag;
    logic heartbeat_flag;
    logic late_collision_flag;
    logic lost_carrier_flag;
    logic jabber_error_flag;
    logic send_starved_flag;
  } lfbe_txres_s;
  typedef struct packed {
    logic short_frame_flag;
    logic own_address_match_flag;
    logic receive_collision_flag;
    logic type_length_flag;
    logic length_error_flag;
    logic crc_error_flag;
    logic alignment_error_flag;
  } lfbe_rxres_s;
  typedef struct packed {
    logic        last;
    logic [15:0] data;
  } lfbe_word_s;
endpackage : lfbe_pkg

//--- lfbe_engine.sv
// Function
// - Host zeroes status; device writes result.
// - Chained blocks sent without further commands.
// - Option: error stops chain or continues.
// - Event per frame or chain end; errors always.
// - Status byte0: defer, heartbeat, maxcol, count.
// - Status byte1: col, ok, late, crs, jab, under.
// - Early collision: jam, backoff, retry.
// - At most fifteen retries after first collision.
// - Retry reloads current from base address.
// - Base advances per finished chained frame.
// - Store data, then header fields, then event.
// - Bad frame discard restores current from base.
// - Upper limit wraps to lower limit.
// - Reaching stop halts storing, raises event.
// - Rx byte0: short, one, address match, col.
// - Rx byte1: type, ok, len, crc, align, over.
// - Bit clock is clock divided by two.
// - Negotiate duplex at reset, else half.
// - Negotiation enable loaded from word bit 9.
module lfbe_engine
  import lfbe_pkg::*;
#(
  parameter int AN_WAIT = AN_WAIT_CYC
) (
  input  wire logic          ref_clk,       // System clock.
  input  wire logic          rst,           // Synchronous reset.
  input  wire logic          send_frame_command, // Start pulse.
  input  wire logic [AW-1:0] cmd_base,      // First block address.
  input  wire logic          stop_on_error, // Errors end the chain.
  input  wire logic          event_each,    // Event per frame.
  input  wire logic          discard_bad,   // Drop errored frames.
  input  wire logic [15:0]   cfg_word0,     // Configuration word 0.
  input  wire logic [AW-1:0] rx_lower,      // Ring lower limit.
  input  wire logic [AW-1:0] rx_upper,      // Ring upper limit.
  input  wire logic [AW-1:0] rx_stop,       // Host stop pointer.
  output logic               tx_mem_req,    // Tx memory request.
  output logic               tx_mem_we,     // Tx write.
  output logic      [AW-1:0] tx_mem_addr,   // Tx address.
  output logic      [15:0]   tx_mem_wdata,  // Tx write data.
  input  wire logic [15:0]   tx_mem_rdata,  // Tx read data.
  input  wire logic          tx_mem_ack,    // Tx access done.
  output logic               rx_mem_req,    // Rx memory request.
  output logic      [AW-1:0] rx_mem_addr,   // Rx address.
  output logic      [15:0]   rx_mem_wdata,  // Rx write data.
  input  wire logic          rx_mem_ack,    // Rx write done.
  output lfbe_word_s         tx_word,       // Word to link.
  output logic               tx_valid,      // Word valid.
  input  wire logic          tx_ready,      // Link takes word.
  input  wire logic          tx_col,        // Early collision pulse.
  output logic               tx_jam,        // Jam request pulse.
  input  wire logic          tx_done,       // Frame finished pulse.
  input  wire lfbe_txres_s   tx_res,        // Result with tx_done.
  input  wire logic          rx_valid,      // Received word valid.
  input  wire logic [15:0]   rx_data,       // Received word.
  input  wire logic          rx_end,        // Frame end pulse.
  input  wire lfbe_rxres_s   rx_res,        // Result with rx_end.
  output logic               rx_ready,      // Room for rx word.
  input  wire logic          hub_ack_pin,   // Hub negotiated, pin.
  input  wire logic          hub_fd_pin,    // Hub full duplex, pin.
  output logic               bit_tick,      // Bit clock enable.
  output logic               full_duplex,   // Negotiated duplex.
  output logic               tx_event,      // Transmit event pulse.
  output logic               rx_eof_event,  // Frame stored pulse.
  output logic               rx_stop_event  // Ring full pulse.
);
  if (AN_WAIT < 1) $error("AN_WAIT must be positive.");

  // *****************************************
  // Bit clock and pin synchronisers
  // *****************************************
  logic       div_reg;
  logic [1:0] ack_s_reg, fd_s_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg   <= 1'b0;
      ack_s_reg <= 2'b00;
      fd_s_reg  <= 2'b00;
    end else begin
      div_reg   <= ~div_reg;
      ack_s_reg <= {ack_s_reg[0], hub_ack_pin};
      fd_s_reg  <= {fd_s_reg[0], hub_fd_pin};
    end
  end
  assign bit_tick = div_reg;

  // *****************************************
  // Duplex negotiation
  // *****************************************
  // The strap is caught on the first cycle after reset lifts.
  logic        an_en_reg, an_go_reg, fd_reg;
  logic [31:0] an_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      an_go_reg  <= 1'b1;
      an_en_reg  <= 1'b0;
      fd_reg     <= 1'b0;
      an_cnt_reg <= 32'h0;
    end else if (an_go_reg) begin
      an_en_reg <= cfg_word0[AN_EN_BIT];
      an_go_reg <= 1'b0;
    end else if (an_en_reg) begin
      if (ack_s_reg[1]) begin
        fd_reg    <= fd_s_reg[1];
        an_en_reg <= 1'b0;
      end else if (an_cnt_reg == 32'(AN_WAIT - 1)) begin
        fd_reg    <= 1'b0;
        an_en_reg <= 1'b0;
      end else begin
        an_cnt_reg <= an_cnt_reg + 32'h1;
      end
    end
  end
  assign full_duplex = fd_reg;

  // *****************************************
  // Two-entry transmit buffer
  // *****************************************
  // A fetch starts only when the buffer is empty, so at most one entry is ever filled.
  lfbe_word_s buf_reg [2];
  logic [1:0] buf_n_reg;
  logic       buf_push, buf_pop, buf_flush;
  lfbe_word_s buf_in;
  assign tx_word  = buf_reg[0];
  assign tx_valid = buf_n_reg != 2'd0;
  assign buf_pop  = tx_valid && tx_ready;
  always_ff @(posedge ref_clk) begin
    if (rst || buf_flush) begin
      buf_n_reg <= 2'd0;
      buf_reg   <= '{default: '0};
    end else begin
      if (buf_pop)
        buf_reg[0] <= (buf_n_reg == 2'd2) ? buf_reg[1] : buf_in;
      if (buf_push && (buf_n_reg == (buf_pop ? 2'd1 : 2'd0)))
        buf_reg[0] <= buf_in;
      if (buf_push && (buf_n_reg - {1'b0, buf_pop}) == 2'd1)
        buf_reg[1] <= buf_in;
      buf_n_reg <= buf_n_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // *****************************************
  // Transmit engine
  // *****************************************
  typedef enum logic [2:0] {
    T_IDLE, T_LEN, T_DATA, T_WAIT, T_BACK, T_STAT
  } lfbe_tx_e;
  lfbe_tx_e    ts_reg;
  logic [AW-1:0] base_reg, cur_reg, left_reg, len_reg;
  logic [3:0]  ncol_reg;
  logic        colseen_reg, maxcol_reg;
  lfbe_txres_s res_reg;
  logic [15:0] lfsr_reg;
  logic [9:0]  slots_reg;
  logic [8:0]  bits_reg;
  logic        tx_err;
  logic [9:0]  bo_mask;
  assign tx_err = maxcol_reg | res_reg.late_collision_flag
    | res_reg.lost_carrier_flag | res_reg.send_starved_flag
    | (res_reg.jabber_error_flag & fd_reg);
  assign bo_mask = 10'((11'h1 << ((ncol_reg > 4'd9) ? 4'd10 : ncol_reg + 4'd1)) - 11'h1);
  assign buf_in  = '{last: left_reg == 16'h1, data: tx_mem_rdata};
  assign buf_push  = (ts_reg == T_DATA) && tx_mem_ack;
  assign buf_flush = (ts_reg == T_WAIT || ts_reg == T_DATA) && tx_col;
  assign tx_jam    = buf_flush;
  assign tx_mem_req  = ((ts_reg == T_DATA) && left_reg != '0 && buf_n_reg == 2'd0)
    || ts_reg == T_LEN || ts_reg == T_STAT;
  assign tx_mem_we   = ts_reg == T_STAT;
  assign tx_mem_addr = (ts_reg == T_LEN) ? base_reg + TX_LEN_OFS
    : (ts_reg == T_STAT) ? base_reg + TX_STAT_OFS : cur_reg;
  // Result word: low byte is status 0, high byte status 1.
  assign tx_mem_wdata = {colseen_reg, 1'b0, ~tx_err, 1'b0,
    res_reg.late_collision_flag, res_reg.lost_carrier_flag,
    res_reg.jabber_error_flag & fd_reg, res_reg.send_starved_flag,
    res_reg.deferred_flag, res_reg.heartbeat_flag, maxcol_reg,
    1'b0, ncol_reg};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ts_reg <= T_IDLE;
      base_reg <= '0;
      cur_reg <= '0;
      left_reg <= '0;
      len_reg <= '0;
      ncol_reg <= '0;
      colseen_reg <= 1'b0;
      maxcol_reg <= 1'b0;
      res_reg <= '0;
      lfsr_reg <= 16'hace1;
      slots_reg <= '0;
      bits_reg <= '0;
      tx_event <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      tx_event <= 1'b0;
      if (buf_flush) begin // A collision while fetching is counted too.
        colseen_reg <= 1'b1;
        if (ncol_reg == MAX_RETRY) begin
          maxcol_reg <= 1'b1;
          res_reg    <= '0;
          ts_reg     <= T_STAT;
        end else begin
          ncol_reg  <= ncol_reg + 4'h1;
          slots_reg <= lfsr_reg[9:0] & bo_mask;
          bits_reg  <= '0;
          ts_reg    <= T_BACK;
        end
      end else case (ts_reg)
        // A command while busy is ignored.
        T_IDLE: if (send_frame_command) begin
          base_reg <= cmd_base;
          ts_reg   <= T_LEN;
        end
        T_LEN: if (tx_mem_ack) begin
          // A zero count word marks the end of the chain.
          if (tx_mem_rdata == 16'h0) begin
            ts_reg   <= T_IDLE;
            tx_event <= ~event_each;
          end else begin
            len_reg <= tx_mem_rdata;
            left_reg <= tx_mem_rdata;
            cur_reg <= base_reg + TX_DATA_OFS;
            ncol_reg <= '0;
            colseen_reg <= 1'b0;
            maxcol_reg <= 1'b0;
            ts_reg <= T_DATA;
          end
        end
        T_DATA: begin
          if (tx_mem_ack) begin
            cur_reg  <= cur_reg + 16'h1;
            left_reg <= left_reg - 16'h1;
          end
          if (left_reg == '0 || (tx_mem_ack && left_reg == 16'h1))
            ts_reg <= T_WAIT;
        end
        T_WAIT: if (tx_done) begin
          res_reg <= tx_res;
          ts_reg  <= T_STAT;
        end
        // Backoff counts slot times in bit ticks.
        T_BACK: if (bit_tick) begin
          if (bits_reg == 9'(SLOT_BITS - 1)) begin
            bits_reg <= '0;
            slots_reg <= slots_reg - 10'h1;
          end else begin
            bits_reg <= bits_reg + 9'h1;
          end
          if (slots_reg == '0) begin
            cur_reg  <= base_reg + TX_DATA_OFS;
            left_reg <= len_reg;
            ts_reg   <= T_DATA;
          end
        end
        T_STAT: if (tx_mem_ack) begin
          tx_event <= event_each | tx_err;
          base_reg <= base_reg + TX_DATA_OFS + len_reg;
          ts_reg   <= (tx_err && stop_on_error) ? T_IDLE : T_LEN;
        end
        default: ts_reg <= T_IDLE;
      endcase
    end
  end

  // *****************************************
  // Receive ring
  // *****************************************
  typedef enum logic [2:0] {
    R_DATA, R_EVT, R_STAT, R_CNT, R_NXT, R_CLR, R_HALT
  } lfbe_rx_e;
  lfbe_rx_e      rs_reg;
  logic [AW-1:0] rbase_reg, rcur_reg, rcnt_reg;
  logic [15:0]   rword_reg, rstat_reg;
  logic          rfull_reg, rover_reg, rerr;
  logic [AW-1:0] rnext;
  function automatic logic [AW-1:0] ring_add(logic [AW-1:0] a, logic [AW-1:0] n);
    logic [AW-1:0] r;
    r = a;
    for (int i = 0; i < 4; i++)
      if (16'(i) < n)
        r = (r == rx_upper) ? rx_lower : r + 16'h1;
    return r;
  endfunction : ring_add
  assign rnext    = ring_add(rcur_reg, 16'h1);
  assign rerr     = rx_res.length_error_flag | rx_res.crc_error_flag
    | rx_res.alignment_error_flag | rx_res.short_frame_flag | rover_reg;
  assign rx_ready = (rs_reg == R_DATA) && !rfull_reg;
  assign rx_mem_req = (rs_reg == R_DATA && rfull_reg)
    || (rs_reg != R_DATA && rs_reg != R_HALT);
  assign rx_mem_addr = (rs_reg == R_DATA || rs_reg == R_CLR) ? rcur_reg
    : ring_add(rbase_reg, (rs_reg == R_EVT) ? RX_EVT_OFS
    : (rs_reg == R_STAT) ? RX_STAT_OFS
    : (rs_reg == R_CNT) ? RX_CNT_OFS : RX_NXT_OFS);
  assign rx_mem_wdata = (rs_reg == R_DATA) ? rword_reg
    : (rs_reg == R_EVT) ? RX_EVT_DONE
    : (rs_reg == R_STAT) ? rstat_reg
    : (rs_reg == R_CNT) ? rcnt_reg
    : (rs_reg == R_NXT) ? rcur_reg : 16'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rs_reg <= R_DATA;
      rbase_reg <= rx_lower;
      rcur_reg <= ring_add(rx_lower, RX_HDR_LEN);
      rcnt_reg <= '0;
      rword_reg <= '0;
      rstat_reg <= '0;
      rfull_reg <= 1'b0;
      rover_reg <= 1'b0;
      rx_eof_event <= 1'b0;
      rx_stop_event <= 1'b0;
    end else begin
      rx_eof_event  <= 1'b0;
      rx_stop_event <= 1'b0;
      case (rs_reg)
        R_DATA: begin
          if (rx_valid && rx_ready) begin
            rword_reg <= rx_data;
            rfull_reg <= 1'b1;
          end
          if (rfull_reg && rx_mem_ack) begin
            rfull_reg <= 1'b0;
            rcnt_reg  <= rcnt_reg + 16'h2;
            rcur_reg <= rnext;
            if (rnext == rx_stop) begin
              rx_stop_event <= 1'b1;
              rs_reg <= R_HALT;
            end
          end
          // An end that meets a pending word is ignored, not held for its write.
          if (rx_end && !rfull_reg) begin
            rstat_reg <= {1'b1 & rx_res.type_length_flag, 1'b0,
              ~rerr, rx_res.length_error_flag, rx_res.crc_error_flag,
              rx_res.alignment_error_flag, 1'b0, rover_reg,
              rx_res.short_frame_flag, 2'b00, 1'b1, 2'b00,
              rx_res.own_address_match_flag, rx_res.receive_collision_flag};
            if (rerr && discard_bad) begin
              rcur_reg <= ring_add(rbase_reg, RX_HDR_LEN);
              rcnt_reg <= '0;
              rover_reg <= 1'b0;
            end else begin
              rs_reg <= R_EVT;
            end
          end
        end
        R_EVT:  if (rx_mem_ack) rs_reg <= R_STAT;
        R_STAT: if (rx_mem_ack) rs_reg <= R_CNT;
        R_CNT:  if (rx_mem_ack) rs_reg <= R_NXT;
        R_NXT:  if (rx_mem_ack) rs_reg <= R_CLR;
        R_CLR: if (rx_mem_ack) begin
          rx_eof_event <= 1'b1;
          rbase_reg <= rcur_reg;
          rcur_reg  <= ring_add(rcur_reg, RX_HDR_LEN);
          rcnt_reg  <= '0;
          rover_reg <= 1'b0;
          rs_reg    <= R_DATA;
        end
        // Storing resumes once the host moves the stop pointer.
        R_HALT: if (rcur_reg != rx_stop) begin
          rover_reg <= 1'b1;
          rs_reg    <= R_DATA;
        end
        default: rs_reg <= R_DATA;
      endcase
    end
  end
endmodule : lfbe_engine

//--- lfbe_mem_model.sv
module lfbe_mem_model
  import lfbe_pkg::*;
(
  input  wire logic          clk,   // Clock.
  input  wire logic [1:0]    dly,   // Wait cycles.
  input  wire logic          a_req, // Tx request.
  input  wire logic          a_we,  // Tx write.
  input  wire logic [AW-1:0] a_adr, // Tx address.
  input  wire logic [15:0]   a_wd,  // Tx write data.
  output logic      [15:0]   a_rd,  // Tx read data.
  output logic               a_ack, // Tx done.
  input  wire logic          b_req, // Rx request.
  input  wire logic [AW-1:0] b_adr, // Rx address.
  input  wire logic [15:0]   b_wd,  // Rx write data.
  output logic               b_ack  // Rx done.
);
  // ****************************************
  // Local buffer memory
  // ****************************************
  logic [15:0] mem [0:65535];
  int          a_n = 0;
  int          b_n = 0;
  initial a_rd = 16'h0000;
  initial a_ack = 1'b0;
  initial b_ack = 1'b0;
  // Each access waits dly cycles, then one acknowledge cycle.
  // Off the acknowledge the read bus toggles, so stale data is never mistaken for a reply.
  always @(posedge clk) begin
    a_ack <= 1'b0;
    b_ack <= 1'b0;
    a_rd <= ~a_rd;
    a_n <= (a_req && !a_ack) ? a_n + 1 : 0;
    b_n <= (b_req && !b_ack) ? b_n + 1 : 0;
    if (a_req && !a_ack && a_n >= dly) begin
      a_ack <= 1'b1;
      a_n <= 0;
      if (a_we) mem[a_adr] <= a_wd;
      else a_rd <= mem[a_adr];
    end
    if (b_req && !b_ack && b_n >= dly) begin
      b_ack <= 1'b1;
      b_n <= 0;
      mem[b_adr] <= b_wd;
    end
  end
endmodule : lfbe_mem_model

//--- lfbe_engine_asserts.sv
module lfbe_engine_chk
  import lfbe_pkg::*;
(
  input wire logic          ref_clk,       // Clock.
  input wire logic          rst,           // Reset.
  input wire logic [15:0]   cfg_word0,     // Config word.
  input wire logic [AW-1:0] rx_lower,      // Ring low.
  input wire logic [AW-1:0] rx_upper,      // Ring high.
  input wire logic          rx_ready,      // Rx room.
  input wire logic          rx_mem_req,    // Rx store.
  input wire logic [AW-1:0] rx_mem_addr,   // Rx address.
  input wire logic          rx_stop_event, // Ring full.
  input wire logic          rx_eof_event,  // Frame stored.
  input wire logic          tx_mem_req,    // Tx access.
  input wire logic          tx_mem_we,     // Tx write.
  input wire logic [15:0]   tx_mem_wdata,  // Tx data.
  input wire logic [AW-1:0] tx_mem_addr,   // Tx address.
  input wire logic          tx_mem_ack,    // Tx done.
  input wire logic          tx_col,        // Collision.
  input wire logic          tx_jam,        // Jam.
  input wire logic          tx_event,      // Tx event.
  input wire logic          bit_tick,      // Bit enable.
  input wire logic          full_duplex    // Duplex.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Port relations
  // ****************************************
  tick_toggle_a: assert property (!$past(rst) |-> bit_tick != $past(bit_tick))
    else $error("bit tick held");
  an_off_a: assert property (!cfg_word0[AN_EN_BIT] |-> !full_duplex)
    else $error("duplex without negotiation");
  jam_cause_a: assert property (tx_jam |-> tx_col)
    else $error("jam without collision");
  stat_ok_a: assert property (tx_mem_req && tx_mem_we |-> tx_mem_wdata[13] == !(|{tx_mem_wdata[11:8], tx_mem_wdata[5]}))
    else $error("success bit wrong");
  stat_zero_a: assert property (tx_mem_req && tx_mem_we |-> !tx_mem_wdata[12])
    else $error("status bit 12 set");
  req_hold_a: assert property (tx_mem_req && !tx_mem_ack && !tx_jam |=> tx_mem_req && $stable(tx_mem_addr))
    else $error("tx access dropped");
  ring_range_a: assert property (rx_mem_req |-> rx_mem_addr >= rx_lower && rx_mem_addr <= rx_upper)
    else $error("rx store outside ring");
  stop_halt_a: assert property (rx_stop_event |-> !rx_ready)
    else $error("rx open at stop");
  // Main scenarios reached.
  cover property (tx_jam);
  cover property (tx_event);
  cover property (rx_eof_event);
  cover property (rx_stop_event);
endmodule : lfbe_engine_chk

bind lfbe_engine lfbe_engine_chk u_chk (.ref_clk(ref_clk), .rst(rst), .cfg_word0(cfg_word0), .rx_lower(rx_lower),
  .rx_upper(rx_upper), .rx_ready(rx_ready), .rx_mem_req(rx_mem_req), .rx_mem_addr(rx_mem_addr),
  .rx_stop_event(rx_stop_event), .rx_eof_event(rx_eof_event), .tx_mem_req(tx_mem_req), .tx_mem_we(tx_mem_we),
  .tx_mem_wdata(tx_mem_wdata), .tx_mem_addr(tx_mem_addr), .tx_mem_ack(tx_mem_ack), .tx_col(tx_col),
  .tx_jam(tx_jam), .tx_event(tx_event), .bit_tick(bit_tick), .full_duplex(full_duplex));

//--- tb_lfbe_engine.sv
module tb_lfbe_engine
  import lfbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bench
  // ****************************************
  localparam int LIM = 20000;
  logic        ref_clk, rst, cmd, soe, each, disc, t_rdy, t_col, t_done, r_vld, r_end, hub;
  logic        m_req, m_we, m_ack, r_req, r_ack, t_vld, t_jam, tick, fd, t_ev, r_eof, r_stp, r_rdy;
  logic [15:0] base, cfg, lo, up, stp, r_dat, m_rd, m_wd, r_wd, m_adr, r_adr, rq[$], got[$];
  logic [1:0]  dly = 2'h0;
  lfbe_word_s  t_word;
  lfbe_txres_s t_res;
  lfbe_rxres_s r_res;
  int          fail_count = 0, check_count = 0, n_ev = 0, n_eof = 0, sflag = 0;

  lfbe_engine #(.AN_WAIT(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .send_frame_command(cmd), .cmd_base(base),
    .stop_on_error(soe), .event_each(each), .discard_bad(disc), .cfg_word0(cfg), .rx_lower(lo), .rx_upper(up),
    .rx_stop(stp), .tx_mem_req(m_req), .tx_mem_we(m_we), .tx_mem_addr(m_adr), .tx_mem_wdata(m_wd),
    .tx_mem_rdata(m_rd), .tx_mem_ack(m_ack), .rx_mem_req(r_req), .rx_mem_addr(r_adr), .rx_mem_wdata(r_wd),
    .rx_mem_ack(r_ack), .tx_word(t_word), .tx_valid(t_vld), .tx_ready(t_rdy), .tx_col(t_col), .tx_jam(t_jam),
    .tx_done(t_done), .tx_res(t_res), .rx_valid(r_vld), .rx_data(r_dat), .rx_end(r_end), .rx_res(r_res),
    .rx_ready(r_rdy), .hub_ack_pin(hub), .hub_fd_pin(hub), .bit_tick(tick), .full_duplex(fd),
    .tx_event(t_ev), .rx_eof_event(r_eof), .rx_stop_event(r_stp));
  lfbe_mem_model u_mem (.clk(ref_clk), .dly(dly), .a_req(m_req), .a_we(m_we), .a_adr(m_adr), .a_wd(m_wd),
    .a_rd(m_rd), .a_ack(m_ack), .b_req(r_req), .b_adr(r_adr), .b_wd(r_wd), .b_ack(r_ack));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Pulses are counted here so that no one-cycle event slips past a task; the memory delay is drawn at random each cycle.
  always @(posedge ref_clk) begin
    dly <= 2'($urandom_range(0, 3));
    if (t_ev === 1'b1) n_ev++;
    if (r_eof === 1'b1) n_eof++;
  end

  task automatic tk();
    @(posedge ref_clk);
    #1;
  endtask : tk
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic lim(logic ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] wait exp done got timeout");
      end_sim();
    end
  endtask : lim
  task automatic wait_n(int tx, int e);
    int k;
    for (k = 0; k < LIM && (tx ? n_ev : n_eof) < e; k++) tk();
    lim((tx ? n_ev : n_eof) >= e);
  endtask : wait_n
  // Expected transmit status; jabber counts only in full duplex, which the bench negotiates.
  function automatic logic [15:0] tx_stat(lfbe_txres_s r, logic [3:0] nc);
    logic e;
    e = r.late_collision_flag | r.lost_carrier_flag | r.jabber_error_flag | r.send_starved_flag;
    return {nc != 0, 1'b0, !e, 1'b0, r.late_collision_flag, r.lost_carrier_flag, r.jabber_error_flag,
            r.send_starved_flag, r.deferred_flag, r.heartbeat_flag, 2'b00, nc};
  endfunction : tx_stat
  function automatic logic [15:0] rx_stat(lfbe_rxres_s r);
    logic ok;
    ok = !(r.short_frame_flag | r.length_error_flag | r.crc_error_flag | r.alignment_error_flag);
    return {r.type_length_flag, 1'b0, ok, r.length_error_flag, r.crc_error_flag, r.alignment_error_flag, 2'b00,
            r.short_frame_flag, 2'b00, 1'b1, 2'b00, r.own_address_match_flag, 1'b0};
  endfunction : rx_stat
  function automatic lfbe_rxres_s rres();
    lfbe_rxres_s r;
    r = '0;
    r.type_length_flag = 1'($urandom);
    r.own_address_match_flag = 1'($urandom);
    return r;
  endfunction : rres
  // Link side takes words at random pace; a collision pulse after the first word forces a full resend.
  task automatic link_frame(logic col, lfbe_txres_s res);
    int i;
    logic v, l, r;
    logic [15:0] d;
    got.delete();
    for (i = 0; i < LIM; i++) begin
      v = t_vld;
      l = t_word.last;
      d = t_word.data;
      r = 1'($urandom);
      t_rdy = r;
      tk();
      if (v && r && col) begin
        got.delete();
        col = 0;
        t_rdy = 0;
        t_col = 1;
        #1;
        chk("jam", 16'h1, {15'h0, t_jam});
        tk();
        t_col = 0;
      end else if (v && r) begin
        got.push_back(d);
        if (l) break;
      end
    end
    lim(i < LIM);
    t_res = res;
    t_done = 1;
    tk();
    t_done = 0;
  endtask : link_frame
  // Sends one received frame; a stop event is answered by moving the stop pointer clear of the ring.
  task automatic rx_frame(int nw, lfbe_rxres_s res);
    int i, k;
    logic g;
    rq.delete();
    for (i = 0; i < nw; i++) begin
      rq.push_back(16'($urandom));
      r_dat = rq[i];
      r_vld = 1;
      k = 0;
      do begin
        g = r_rdy;
        if (r_stp === 1'b1) begin
          stp = 16'h07ff;
          sflag = 1;
        end
        tk();
        k++;
      end while (g !== 1'b1 && k < LIM);
      lim(g);
    end
    r_vld = 0;
    for (k = 0; k < LIM && r_rdy !== 1'b1; k++) tk();
    lim(k < LIM);
    r_res = res;
    r_end = 1;
    tk();
    r_end = 0;
  endtask : rx_frame
  task automatic rx_hdr(logic [15:0] rb, int nw, lfbe_rxres_s res, output logic [15:0] nx);
    chk("rx_evt", RX_EVT_DONE, u_mem.mem[rb + RX_EVT_OFS]);
    chk("rx_stat", rx_stat(res) & 16'hff93, u_mem.mem[rb + RX_STAT_OFS] & 16'hff93);
    chk("rx_cnt", 16'(2 * nw), u_mem.mem[rb + RX_CNT_OFS]);
    nx = u_mem.mem[rb + RX_NXT_OFS];
    chk("rx_dat", rq[0], u_mem.mem[rb + RX_HDR_LEN]);
    chk("rx_next_evt", 16'h0000, u_mem.mem[nx]);
  endtask : rx_hdr

  initial begin
    int i, f, k;
    logic [15:0] a, nx, bs[3], nn[3];
    lfbe_txres_s tr[3];
    lfbe_rxres_s rr;
    void'($urandom(32'h80f876af));
    {rst, hub, cmd, soe, each, disc, t_rdy, t_col, t_done, r_vld, r_end} = 11'h600;
    {cfg, lo, up, stp, base, r_dat} = {16'(1 << AN_EN_BIT), 16'h0800, 16'h080f, 16'h07ff, 32'h0};
    {t_res, r_res} = '0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 0;
    for (k = 0; k < 100 && fd !== 1'b1; k++) tk();
    chk("duplex", 16'h1, {15'h0, fd});
    // Three staged blocks with cleared status, then an empty block that ends the chain.
    a = 16'h0100;
    for (f = 0; f < 3; f++) begin
      bs[f] = a;
      nn[f] = 16'($urandom_range(1, 4));
      u_mem.mem[a] = 16'h0000;
      u_mem.mem[a + 1] = nn[f];
      for (i = 0; i < nn[f]; i++) u_mem.mem[a + 2 + i] = 16'($urandom);
      tr[f] = lfbe_txres_s'(6'($urandom) & 6'h30);
      a = a + 16'h2 + nn[f];
    end
    tr[1].send_starved_flag = 1'b1;
    u_mem.mem[a + 1] = 16'h0000;
    base = 16'h0100;
    cmd = 1;
    tk();
    cmd = 0;
    for (i = 0; i < nn[2]; i++) u_mem.mem[bs[2] + 2 + i] = 16'($urandom);
    for (f = 0; f < 3; f++) begin
      link_frame(f == 0, tr[f]);
      chk("tx_len", nn[f], 16'(got.size()));
      for (i = 0; i < got.size(); i++) chk("tx_dat", u_mem.mem[bs[f] + 2 + i], got[i]);
    end
    wait_n(1, 2);
    chk("tx_events", 16'h2, 16'(n_ev));
    for (f = 0; f < 3; f++) chk("tx_stat", tx_stat(tr[f], 4'(f == 0)) & 16'hbfef, u_mem.mem[bs[f]] & 16'hbfef);
    // Receive: plain frame, frame across the wrap, dropped bad frame, reuse, then stop reached.
    rr = rres();
    rx_frame(3, rr);
    wait_n(0, 1);
    rx_hdr(lo, 3, rr, nx);
    chk("rx_next", 16'h0807, nx);
    rr.length_error_flag = 1'b1;
    rx_frame(6, rr);
    wait_n(0, 2);
    rx_hdr(16'h0807, 6, rr, nx);
    chk("rx_wrap", 16'h1, {15'h0, nx >= lo && nx < 16'h0807});
    disc = 1;
    rr.crc_error_flag = 1'b1;
    rx_frame(2, rr);
    for (k = 0; k < 300; k++) tk();
    chk("rx_drop", 16'h2, 16'(n_eof));
    chk("rx_drop_evt", 16'h0000, u_mem.mem[nx]);
    rr = rres();
    rx_frame(2, rr);
    wait_n(0, 3);
    rx_hdr(nx, 2, rr, a);
    stp = a + 16'h5;
    rx_frame(4, rres());
    chk("rx_stop", 16'h1, 16'(sflag));
    rst = 1;
    cfg = 16'h0000;
    repeat (3) tk();
    rst = 0;
    repeat (40) tk();
    chk("duplex_off", 16'h0, {15'h0, fd});
    end_sim();
  end
endmodule : tb_lfbe_engine
